/* hdl/jack_switch_pkg.sv */
package jack_switch_pkg;

  // ---------------------------------------------
  // register indices, byte address is index * 4
  // ---------------------------------------------
  localparam logic [7:0] IDX_JACK_CTRL = 8'h18;
  localparam logic [7:0] IDX_DRV_POWER = 8'h1A;
  localparam logic [7:0] IDX_PIN_CFG = 8'h1B;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h1D;
  localparam logic [7:0] IDX_MIC_CMP = 8'h1E;
  localparam logic [7:0] IDX_LIVE = 8'h1F;

  // ---------------------------------------------
  // field positions
  // ---------------------------------------------
  localparam int REG_W = 9;
  localparam int SWITCH_EN_BIT = 6;
  localparam int SWITCH_POL_BIT = 5;
  localparam int LEFT_PHONE_BIT = 6;
  localparam int RIGHT_PHONE_BIT = 5;
  localparam int LEFT_SPK_BIT = 4;
  localparam int RIGHT_SPK_BIT = 3;
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 3;
  localparam logic [2:0] MODE_INPUT = 3'h0;
  localparam logic [2:0] MODE_EVENT = 3'h1;
  localparam int CMP_EN_BIT = 0;
  localparam int THRESH_LSB = 1;
  localparam int THRESH_W = 8;
  localparam int EV_MIC = 0;
  localparam int EV_JACK = 1;
  localparam int EV_W = 2;

  // ---------------------------------------------
  // reset values
  // ---------------------------------------------
  localparam logic [8:0] RST_JACK_CTRL = 9'h000;
  localparam logic [8:0] RST_DRV_POWER = 9'h000;
  localparam logic [8:0] RST_PIN_CFG = 9'h000;
  localparam logic [8:0] RST_MIC_CMP = 9'h000;
  localparam logic [1:0] RST_IRQ = 2'h0;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACCESS = 2'b10
  } bus_state_type;

  typedef struct packed {
    logic left_phone;
    logic right_phone;
    logic left_speaker;
    logic right_speaker;
  } driver_enable_type;

  typedef struct packed {
    bus_state_type bus;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [8:0] jack_ctrl;
    logic [8:0] drv_power;
    logic [8:0] pin_cfg;
    logic [8:0] mic_cmp;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic sense_meta;
    logic sense_sync;
    logic sense_prev;
    logic mic_above;
    driver_enable_type drv;
    logic irq;
    logic pin_o;
    logic pin_oe;
  } state_type;

endpackage

/* hdl/jack_output_switch.sv */
// Chosen here: the APB slave port.
`timescale 1ns/10ps
// Operation
// - With the switch enabled and a headphone sensed, speakers are forced off and phones allowed.
// - Polarity 0 makes a high sense level mean headphone; polarity 1 makes a low level mean it.
// - The switch only masks drivers whose power enables software has already set.
// - The power register holds left/right phone enables at bits 6/5, speaker ones at 4/3.
// - The switch control register holds switch enable at bit 6 and polarity at bit 5.
// - On the general-pin variant, pin mode 000 in bits 2:0 makes the pin the sense input.
// - The mic supply current is compared against a software threshold.
// - A threshold crossing sets a status bit and, in event mode, drives the pin.
module jack_output_switch #(
  parameter bit GENERAL_PIN_SOURCE = 1'b0,
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // jack sense and general pin
  input wire logic jack_sense_pin,
  input wire logic general_sense_pin_i,
  output logic general_sense_pin_o,
  output logic general_sense_pin_oe,
  // mic supply current, digitised
  input wire logic [jack_switch_pkg::THRESH_W-1:0] mic_supply_current,
  // driver gating and interrupt
  output jack_switch_pkg::driver_enable_type drv_enable,
  output logic irq
);

  // ---------------------------------------------
  // decode helpers
  // ---------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, jack_switch_pkg::IDX_JACK_CTRL) | hit(a, jack_switch_pkg::IDX_DRV_POWER)
      | hit(a, jack_switch_pkg::IDX_PIN_CFG) | hit(a, jack_switch_pkg::IDX_IRQ_STATUS)
      | hit(a, jack_switch_pkg::IDX_IRQ_MASK) | hit(a, jack_switch_pkg::IDX_MIC_CMP)
      | hit(a, jack_switch_pkg::IDX_LIVE);
  endfunction

  jack_switch_pkg::state_type s_reg;
  jack_switch_pkg::state_type s_next;

  logic sense_raw;
  logic phone_sel;
  logic [2:0] pin_mode;
  logic [7:0] threshold;
  logic above_now;
  logic [1:0] events;
  logic [1:0] rd_clear;
  logic wr_done;
  logic rd_done;
  logic [3:0] pwr4;

  // ---------------------------------------------
  // datapath terms
  // ---------------------------------------------
  assign pin_mode = s_reg.pin_cfg[jack_switch_pkg::MODE_LSB +: jack_switch_pkg::MODE_W];
  assign threshold = s_reg.mic_cmp[jack_switch_pkg::THRESH_LSB +: jack_switch_pkg::THRESH_W];
  assign pwr4 = {s_reg.drv_power[jack_switch_pkg::LEFT_PHONE_BIT],
                 s_reg.drv_power[jack_switch_pkg::RIGHT_PHONE_BIT],
                 s_reg.drv_power[jack_switch_pkg::LEFT_SPK_BIT],
                 s_reg.drv_power[jack_switch_pkg::RIGHT_SPK_BIT]};

  // general pin only senses while it is an input; otherwise reads as low
  assign sense_raw = GENERAL_PIN_SOURCE ?
    (general_sense_pin_i & (pin_mode == jack_switch_pkg::MODE_INPUT))
    : jack_sense_pin;

  // polarity 1 inverts the synchronised level
  assign phone_sel = s_reg.sense_sync ^ s_reg.jack_ctrl[jack_switch_pkg::SWITCH_POL_BIT];

  assign above_now = s_reg.mic_cmp[jack_switch_pkg::CMP_EN_BIT]
    & (mic_supply_current > threshold);

  // only rising crossings raise the mic event, a steady level does not repeat it; either sense edge raises the jack event
  assign events[jack_switch_pkg::EV_MIC] = above_now & ~s_reg.mic_above;
  assign events[jack_switch_pkg::EV_JACK] = s_reg.sense_sync ^ s_reg.sense_prev;

  assign wr_done = (s_reg.bus == jack_switch_pkg::BUS_ACCESS) & psel & penable & pwrite;
  assign rd_done = (s_reg.bus == jack_switch_pkg::BUS_ACCESS) & psel & penable & ~pwrite;
  // clear only what the read returned, so a later event is not lost
  assign rd_clear = (rd_done & hit(paddr, jack_switch_pkg::IDX_IRQ_STATUS)) ?
    s_reg.prdata[jack_switch_pkg::EV_W-1:0] : 2'h0;

  // ---------------------------------------------
  // next state
  // ---------------------------------------------
  always_comb begin
    s_next = s_reg;
    // two-flop synchroniser on the sense source
    s_next.sense_meta = sense_raw;
    s_next.sense_sync = s_reg.sense_meta;
    s_next.sense_prev = s_reg.sense_sync;
    s_next.mic_above = above_now;
    s_next.irq_status = (s_reg.irq_status & ~rd_clear) | events;

    // bus slave, one wait-free access phase after setup
    unique case (s_reg.bus)
      jack_switch_pkg::BUS_IDLE: begin
        s_next.pready = 1'b0;
        s_next.pslverr = 1'b0;
        if (psel && !penable) begin
          s_next.bus = jack_switch_pkg::BUS_ACCESS;
          s_next.pready = 1'b1;
          s_next.pslverr = ~mapped(paddr);
          s_next.prdata = 32'h0000_0000;
          if (!pwrite) begin
            if (hit(paddr, jack_switch_pkg::IDX_JACK_CTRL)) begin
              s_next.prdata = 32'(s_reg.jack_ctrl);
            end else if (hit(paddr, jack_switch_pkg::IDX_DRV_POWER)) begin
              s_next.prdata = 32'(s_reg.drv_power);
            end else if (hit(paddr, jack_switch_pkg::IDX_PIN_CFG)) begin
              s_next.prdata = 32'(s_reg.pin_cfg);
            end else if (hit(paddr, jack_switch_pkg::IDX_IRQ_STATUS)) begin
              s_next.prdata = 32'(s_reg.irq_status);
            end else if (hit(paddr, jack_switch_pkg::IDX_IRQ_MASK)) begin
              s_next.prdata = 32'(s_reg.irq_mask);
            end else if (hit(paddr, jack_switch_pkg::IDX_MIC_CMP)) begin
              s_next.prdata = 32'(s_reg.mic_cmp);
            end else if (hit(paddr, jack_switch_pkg::IDX_LIVE)) begin
              s_next.prdata = 32'({s_reg.drv, phone_sel, s_reg.sense_sync, s_reg.mic_above});
            end
          end
        end
      end
      jack_switch_pkg::BUS_ACCESS: begin
        if (psel && penable) begin
          s_next.bus = jack_switch_pkg::BUS_IDLE;
          s_next.pready = 1'b0;
          s_next.pslverr = 1'b0;
        end
      end
      default: begin
        s_next.bus = jack_switch_pkg::BUS_IDLE;
        s_next.pready = 1'b0;
        s_next.pslverr = 1'b0;
      end
    endcase

    if (wr_done) begin
      if (hit(paddr, jack_switch_pkg::IDX_JACK_CTRL)) begin
        s_next.jack_ctrl = pwdata[jack_switch_pkg::REG_W-1:0];
      end
      if (hit(paddr, jack_switch_pkg::IDX_DRV_POWER)) begin
        s_next.drv_power = pwdata[jack_switch_pkg::REG_W-1:0];
      end
      if (hit(paddr, jack_switch_pkg::IDX_PIN_CFG)) begin
        s_next.pin_cfg = pwdata[jack_switch_pkg::REG_W-1:0];
      end
      if (hit(paddr, jack_switch_pkg::IDX_IRQ_MASK)) begin
        s_next.irq_mask = pwdata[jack_switch_pkg::EV_W-1:0];
      end
      if (hit(paddr, jack_switch_pkg::IDX_MIC_CMP)) begin
        s_next.mic_cmp = pwdata[jack_switch_pkg::REG_W-1:0];
      end
    end

    // gating can only remove a driver that software powered
    s_next.drv.left_phone = pwr4[3]
      & (~s_reg.jack_ctrl[jack_switch_pkg::SWITCH_EN_BIT] | phone_sel);
    s_next.drv.right_phone = pwr4[2]
      & (~s_reg.jack_ctrl[jack_switch_pkg::SWITCH_EN_BIT] | phone_sel);
    s_next.drv.left_speaker = pwr4[1]
      & (~s_reg.jack_ctrl[jack_switch_pkg::SWITCH_EN_BIT] | ~phone_sel);
    s_next.drv.right_speaker = pwr4[0]
      & (~s_reg.jack_ctrl[jack_switch_pkg::SWITCH_EN_BIT] | ~phone_sel);

    s_next.irq = |(s_reg.irq_status & s_reg.irq_mask);
    // any mode but input drives the pin; event mode shows the mic status
    s_next.pin_oe = (pin_mode != jack_switch_pkg::MODE_INPUT);
    s_next.pin_o = (pin_mode == jack_switch_pkg::MODE_EVENT)
      & s_reg.irq_status[jack_switch_pkg::EV_MIC];
  end

  // ---------------------------------------------
  // state register
  // ---------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.bus <= jack_switch_pkg::BUS_IDLE;
      s_reg.jack_ctrl <= jack_switch_pkg::RST_JACK_CTRL;
      s_reg.drv_power <= jack_switch_pkg::RST_DRV_POWER;
      s_reg.pin_cfg <= jack_switch_pkg::RST_PIN_CFG;
      s_reg.mic_cmp <= jack_switch_pkg::RST_MIC_CMP;
      s_reg.irq_status <= jack_switch_pkg::RST_IRQ;
      s_reg.irq_mask <= jack_switch_pkg::RST_IRQ;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign drv_enable = s_reg.drv;
  assign irq = s_reg.irq;
  assign general_sense_pin_o = s_reg.pin_o;
  assign general_sense_pin_oe = s_reg.pin_oe;

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence power_write_s;
    wr_done && hit(paddr, jack_switch_pkg::IDX_DRV_POWER);
  endsequence

  sequence ctrl_write_s;
    wr_done && hit(paddr, jack_switch_pkg::IDX_JACK_CTRL);
  endsequence

  sequence status_read_s;
    rd_done && hit(paddr, jack_switch_pkg::IDX_IRQ_STATUS);
  endsequence

  // rising crossing of an enabled comparator, as the event logic sees it
  sequence mic_cross_s;
    s_reg.mic_cmp[jack_switch_pkg::CMP_EN_BIT] && (mic_supply_current > threshold)
    && !s_reg.mic_above;
  endsequence

  a_phone_mutes_speaker: assert property (
    s_reg.jack_ctrl[jack_switch_pkg::SWITCH_EN_BIT] && phone_sel
    |=> !drv_enable.left_speaker && !drv_enable.right_speaker)
    else $error("speaker left on while headphone selected");

  a_phone_off_speaker: assert property (
    s_reg.jack_ctrl[jack_switch_pkg::SWITCH_EN_BIT] && !phone_sel
    |=> !drv_enable.left_phone && !drv_enable.right_phone)
    else $error("headphone left on while speaker selected");

  a_polarity_sense: assert property (
    s_reg.jack_ctrl[jack_switch_pkg::SWITCH_EN_BIT] && (pwr4 == 4'hF)
    && (s_reg.sense_sync != s_reg.jack_ctrl[jack_switch_pkg::SWITCH_POL_BIT])
    |=> drv_enable.left_phone && drv_enable.right_phone)
    else $error("sense level and polarity did not select phones");

  a_never_powers_up: assert property (
    ##1 ((drv_enable & ~$past(pwr4)) == 4'h0))
    else $error("driver enabled without its power bit");

  a_switch_off_follows: assert property (
    !s_reg.jack_ctrl[jack_switch_pkg::SWITCH_EN_BIT] |=> drv_enable == $past(pwr4))
    else $error("disabled switch still gates a driver");

  a_power_field_write: assert property (
    power_write_s |=> s_reg.drv_power == $past(pwdata[8:0]))
    else $error("power register write not stored");

  a_ctrl_field_write: assert property (
    ctrl_write_s |=> s_reg.jack_ctrl == $past(pwdata[8:0]))
    else $error("switch control write not stored");

  a_pin_input_mode: assert property (
    pin_mode == jack_switch_pkg::MODE_INPUT |=> !general_sense_pin_oe)
    else $error("pin driven while in input mode");

  a_sense_source: assert property (
    (pin_mode == jack_switch_pkg::MODE_INPUT)
    |-> sense_raw == (GENERAL_PIN_SOURCE ? general_sense_pin_i : jack_sense_pin))
    else $error("input-mode pin does not feed the sense path");

  a_mic_threshold: assert property (
    mic_cross_s |=> s_reg.irq_status[jack_switch_pkg::EV_MIC] && s_reg.mic_above)
    else $error("mic crossing not flagged");

  a_mic_event_pin: assert property (
    s_reg.irq_status[jack_switch_pkg::EV_MIC] && pin_mode == jack_switch_pkg::MODE_EVENT
    |=> general_sense_pin_o && general_sense_pin_oe)
    else $error("event pin not asserted");

  // a mask write in the crossing cycle would legally change the outcome
  a_mic_irq_path: assert property (
    mic_cross_s ##0 (s_reg.irq_mask[jack_switch_pkg::EV_MIC] && !wr_done) |-> ##2 irq)
    else $error("unmasked mic crossing did not raise the interrupt");

  a_status_read_clears: assert property (
    status_read_s ##0 (s_reg.prdata[jack_switch_pkg::EV_MIC] && !events[jack_switch_pkg::EV_MIC])
    |=> !s_reg.irq_status[jack_switch_pkg::EV_MIC])
    else $error("mic status not cleared by its read");

  a_sense_two_flops: assert property (
    ##2 s_reg.sense_sync == $past(sense_raw, 2))
    else $error("sense not synchronised in two cycles");

  a_irq_level: assert property (
    ##1 irq == $past(|(s_reg.irq_status & s_reg.irq_mask)))
    else $error("interrupt does not follow masked status");

endmodule

/* dv/jack_socket_model.sv */
`timescale 1ns/10ps
module jack_socket_model (
  // clock
  input wire logic pclk,
  // device pins
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic jack_sense_pin,
  output logic general_sense_pin_i,
  output logic [jack_switch_pkg::THRESH_W-1:0] mic_supply_current
);
  logic inserted = 1'b0;
  logic [jack_switch_pkg::THRESH_W-1:0] mic_draw = 8'h00;

  // pull-up gives 1 with a plug in, the divider gives 0 without
  assign jack_sense_pin = inserted;
  // shared pin follows the device whenever it drives
  assign general_sense_pin_i = pin_oe ? pin_o : inserted;
  // an empty socket draws no bias current
  assign mic_supply_current = inserted ? mic_draw : 8'h00;

  task automatic plug(input logic present);
    @(posedge pclk);
    inserted <= present;
  endtask

  task automatic draw(input logic [7:0] amount);
    @(posedge pclk);
    mic_draw <= amount;
  endtask
endmodule

/* dv/headphone_jack_output_switch_tb.sv */
`timescale 1ns/10ps
module headphone_jack_output_switch_tb;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  jack_switch_pkg::driver_enable_type drv_enable_gp;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic jack_sense_pin;
  logic general_sense_pin_i;
  logic general_sense_pin_o;
  logic general_sense_pin_oe;
  logic [7:0] mic_supply_current;
  jack_switch_pkg::driver_enable_type drv_enable;
  logic irq;
  logic [31:0] rd;
  logic err;
  int fails = 0;
  int checked = 0;

  always #5 pclk = ~pclk;

  jack_output_switch dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .jack_sense_pin(jack_sense_pin), .general_sense_pin_i(general_sense_pin_i),
    .general_sense_pin_o(general_sense_pin_o), .general_sense_pin_oe(general_sense_pin_oe),
    .mic_supply_current(mic_supply_current), .drv_enable(drv_enable), .irq(irq)
  );

  // general-pin variant, fed the same bus traffic and socket
  jack_output_switch #(.GENERAL_PIN_SOURCE(1'b1)) dut_gp (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .jack_sense_pin(jack_sense_pin), .general_sense_pin_i(general_sense_pin_i),
    .general_sense_pin_o(), .general_sense_pin_oe(),
    .mic_supply_current(mic_supply_current), .drv_enable(drv_enable_gp), .irq()
  );

  jack_socket_model socket (
    .pclk(pclk), .pin_o(general_sense_pin_o), .pin_oe(general_sense_pin_oe),
    .jack_sense_pin(jack_sense_pin), .general_sense_pin_i(general_sense_pin_i),
    .mic_supply_current(mic_supply_current)
  );

  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      fails++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic put(input logic [7:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask

  task automatic rd_check(input logic [7:0] idx, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, idx, 32'h0);
    check(rd, exp);
    check({31'h0, err}, {31'h0, exp_err});
  endtask

  // outputs are judged at the falling edge, well clear of updates
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  function automatic logic [31:0] expect_drv(logic [3:0] pw, logic en, logic pol, logic s);
    if (!en) return {28'h0, pw};
    return (s ^ pol) ? {28'h0, pw[3:2], 2'h0} : {28'h0, 2'h0, pw[1:0]};
  endfunction

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic reset_values();
    rd_check(jack_switch_pkg::IDX_JACK_CTRL, 32'h0, 1'b0);
    rd_check(jack_switch_pkg::IDX_DRV_POWER, 32'h0, 1'b0);
    rd_check(jack_switch_pkg::IDX_PIN_CFG, 32'h0, 1'b0);
    rd_check(jack_switch_pkg::IDX_MIC_CMP, 32'h0, 1'b0);
    rd_check(8'h00, 32'h0, 1'b1);
    settle(0);
    check({28'h0, drv_enable}, 32'h0);
  endtask

  task automatic power_bits();
    for (int i = 3; i < 7; i++) begin
      put(jack_switch_pkg::IDX_DRV_POWER, 32'h1 << i);
      settle(2);
      check({28'h0, drv_enable}, 32'h1 << (i - 3));
      rd_check(jack_switch_pkg::IDX_DRV_POWER, 32'h1 << i, 1'b0);
    end
  endtask

  task automatic switch_sense();
    put(jack_switch_pkg::IDX_DRV_POWER, 32'h78);
    for (int p = 0; p < 2; p++) begin
      put(jack_switch_pkg::IDX_JACK_CTRL, 32'h40 | (p << 5));
      rd_check(jack_switch_pkg::IDX_JACK_CTRL, 32'h40 | (p << 5), 1'b0);
      socket.plug(1'b0);
      settle(4);
      for (int s = 1; s >= 0; s--) begin
        socket.plug(s[0]);
        // one edge in, the synchroniser must still hold the old level
        settle(1);
        check({28'h0, drv_enable}, expect_drv(4'hF, 1'b1, p[0], ~s[0]));
        check({28'h0, drv_enable_gp}, expect_drv(4'hF, 1'b1, p[0], ~s[0]));
        settle(2);
        check({28'h0, drv_enable}, expect_drv(4'hF, 1'b1, p[0], s[0]));
        check({28'h0, drv_enable_gp}, expect_drv(4'hF, 1'b1, p[0], s[0]));
      end
    end
    // socket empty, inverted polarity: phones on, sense low
    rd_check(jack_switch_pkg::IDX_LIVE, 32'h64, 1'b0);
    // sense changes above left the jack event pending
    rd_check(jack_switch_pkg::IDX_IRQ_STATUS, 32'h2, 1'b0);
  endtask

  task automatic suppress_only();
    put(jack_switch_pkg::IDX_JACK_CTRL, 32'h40);
    put(jack_switch_pkg::IDX_DRV_POWER, 32'h60);
    settle(4);
    check({28'h0, drv_enable}, 32'h0);
    socket.plug(1'b1);
    settle(4);
    check({28'h0, drv_enable}, expect_drv(4'hC, 1'b1, 1'b0, 1'b1));
    put(jack_switch_pkg::IDX_JACK_CTRL, 32'h0);
    socket.plug(1'b0);
    settle(4);
    check({28'h0, drv_enable}, expect_drv(4'hC, 1'b0, 1'b0, 1'b0));
  endtask

  task automatic mic_detect();
    put(jack_switch_pkg::IDX_PIN_CFG, 32'h1);
    settle(1);
    check({31'h0, general_sense_pin_oe}, 32'h1);
    put(jack_switch_pkg::IDX_IRQ_MASK, 32'h1);
    put(jack_switch_pkg::IDX_MIC_CMP, 32'h081);
    socket.plug(1'b1);
    socket.draw(8'h40);
    apb(1'b0, jack_switch_pkg::IDX_IRQ_STATUS, 32'h0);
    settle(3);
    check({31'h0, irq}, 32'h0);
    socket.draw(8'h41);
    settle(3);
    check({31'h0, irq}, 32'h1);
    check({31'h0, general_sense_pin_o}, 32'h1);
    apb(1'b0, jack_switch_pkg::IDX_IRQ_STATUS, 32'h0);
    check(rd & 32'h1, 32'h1);
    settle(3);
    check({31'h0, irq}, 32'h0);
    put(jack_switch_pkg::IDX_IRQ_MASK, 32'h0);
    socket.draw(8'h00);
    socket.draw(8'h41);
    settle(3);
    check({31'h0, irq}, 32'h0);
    apb(1'b0, jack_switch_pkg::IDX_IRQ_STATUS, 32'h0);
    check(rd & 32'h1, 32'h1);
    put(jack_switch_pkg::IDX_PIN_CFG, 32'h0);
    settle(1);
    check({31'h0, general_sense_pin_oe}, 32'h0);
  endtask

  initial begin
    pclk = 1'b0;
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0000_0000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    reset_values();
    power_bits();
    switch_sense();
    suppress_only();
    mic_detect();
    complete_run();
  end
endmodule
